// >>> hdl/sbcms_defs.svh
// timing counts and encodings for the operating-mode controller
// assumes a 200 MHz ref_clk; included by bare name
`ifndef SBCMS_DEFS_SVH
`define SBCMS_DEFS_SVH
`define SBCMS_CLK_MHZ          200
`define SBCMS_RESET_DELAY_US   10
`define SBCMS_RESET_DELAY_CYC  (`SBCMS_RESET_DELAY_US * `SBCMS_CLK_MHZ)
`define SBCMS_LONG_WIN_MS      200
`define SBCMS_LONG_WIN_CYC     (`SBCMS_LONG_WIN_MS * 1000 * `SBCMS_CLK_MHZ)
`define SBCMS_FILT_US          5
`define SBCMS_FILT_CYC         (`SBCMS_FILT_US * `SBCMS_CLK_MHZ)
`define SBCMS_MODE_NORMAL      3'h0
`define SBCMS_MODE_STOP        3'h1
`define SBCMS_MODE_SLEEP       3'h2
`define SBCMS_MODE_RESET_REQ   3'h3
`endif

// >>> hdl/sbcms_pkg.sv
// types for the operating-mode controller
// assumes sbcms_defs.svh holds the numeric constants
package sbcms_pkg;
   typedef enum logic [2:0] {
      st_init, st_normal, st_stop, st_sleep, st_restart, st_failsafe
   } sbcms_mode_type;
   typedef struct packed {
      logic wd_fail;
      logic ov_event;
      logic wake;
      logic ot_clear;
      logic uv_event;
   } sbcms_event_type;
endpackage : sbcms_pkg

// >>> hdl/sbcms_top.sv
// operating-mode controller of a system basis chip
// assumes events come from on-chip logic on ref_clk; strap pins are asynchronous
`timescale 1ns/1ps
`include "sbcms_defs.svh"
module sbcms_top #(
   parameter int unsigned RESET_DELAY_CYC = `SBCMS_RESET_DELAY_CYC,
   parameter int unsigned LONG_WIN_CYC    = `SBCMS_LONG_WIN_CYC,
   parameter int unsigned FILT_CYC        = `SBCMS_FILT_CYC
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     spi_frame_done,
   input  wire logic                     mode_write,
   input  wire logic [2:0]               mode_write_data,
   input  wire logic                     wd_trigger,
   input  wire sbcms_pkg::sbcms_event_type evt,
   input  wire logic                     threshold_select,
   input  wire logic                     overvoltage_reset_enable,
   input  wire logic                     power_on_flag,
   input  wire logic                     main_regulator_ok,
   input  wire logic                     int_pin_in,
   input  wire logic                     debug_strap_pin,
   output logic [2:0]                    operating_mode_field,
   output sbcms_pkg::sbcms_mode_type     mode_state,
   output logic                          reset_output,
   output logic                          main_regulator_en,
   output logic                          int_pulldown_en,
   output logic                          fail_outputs,
   output logic                          main_overvoltage_flag,
   output logic                          strap_level_latched,
   output logic                          threshold_select_rb,
   output logic                          development_mode,
   output logic                          watchdog_fail_flag
);
   // refuse counts that leave the strap filter no time to settle before the latch
   if (RESET_DELAY_CYC < 2 || LONG_WIN_CYC < 1 || FILT_CYC < 1 ||
       FILT_CYC + 8 > RESET_DELAY_CYC) begin : g_bad_counts
      $error("sbcms_top: count parameters out of range");
   end

   sbcms_pkg::sbcms_mode_type state_reg, state_next;
   logic [31:0] delay_cnt_reg;
   logic [31:0] win_cnt_reg;
   logic [31:0] filt_cnt_reg;
   logic [2:0]  int_sync_reg;
   logic [2:0]  dbg_sync_reg;
   logic        int_filt_reg;
   logic        int_stable_reg;
   logic        wd_fail_cnt_reg;
   logic        first_boot_reg;
   logic        win_open_reg;
   logic        wd_fail_now;
   logic        ov_act;
   logic        delay_done;

   // restart or fail-safe outcome of a watchdog failure
   function automatic sbcms_pkg::sbcms_mode_type fail_target(input logic strap,
                                                            input logic sel,
                                                            input logic second);
      if (strap)
         fail_target = sbcms_pkg::st_restart;
      else if (!sel && !second)
         fail_target = sbcms_pkg::st_restart;
      else
         fail_target = sbcms_pkg::st_failsafe;
   endfunction : fail_target

   // three-stage synchronisers for the two strap pins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_sync_reg <= 3'h0;
         dbg_sync_reg <= 3'h7;
      end else begin
         int_sync_reg <= {int_sync_reg[1:0], int_pin_in};
         dbg_sync_reg <= {dbg_sync_reg[1:0], debug_strap_pin};
      end
   end

   // watchdog failures: missed long window, or external trigger failure
   assign wd_fail_now = !development_mode &&
                        ((win_open_reg && win_cnt_reg == 32'h0) || evt.wd_fail);
   assign ov_act      = evt.ov_event && overvoltage_reset_enable;
   assign delay_done  = delay_cnt_reg == 32'h0;

   // mode sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sbcms_pkg::st_init: begin
            // wake events are simply not looked at here
            if (wd_fail_now)
               state_next = sbcms_pkg::st_restart;
            else if (spi_frame_done)
               state_next = sbcms_pkg::st_normal;
         end
         sbcms_pkg::st_normal, sbcms_pkg::st_stop: begin
            if (wd_fail_now)
               state_next = fail_target(strap_level_latched, threshold_select,
                                        wd_fail_cnt_reg);
            else if (ov_act)
               state_next = strap_level_latched ? sbcms_pkg::st_restart
                                                : sbcms_pkg::st_failsafe;
            else if (evt.uv_event)
               state_next = sbcms_pkg::st_restart;
            else if (mode_write) begin
               case (mode_write_data)
                  `SBCMS_MODE_NORMAL:    state_next = sbcms_pkg::st_normal;
                  `SBCMS_MODE_STOP:      state_next = sbcms_pkg::st_stop;
                  `SBCMS_MODE_SLEEP:     state_next = (state_reg == sbcms_pkg::st_stop)
                                                      ? sbcms_pkg::st_restart
                                                      : sbcms_pkg::st_sleep;
                  `SBCMS_MODE_RESET_REQ: state_next = sbcms_pkg::st_restart;
                  default:               state_next = state_reg;
               endcase
            end
         end
         sbcms_pkg::st_sleep: begin
            if (evt.wake)
               state_next = sbcms_pkg::st_restart;
         end
         sbcms_pkg::st_restart: begin
            if (delay_done && !evt.uv_event && main_regulator_ok)
               state_next = sbcms_pkg::st_normal;
         end
         sbcms_pkg::st_failsafe: begin
            if (evt.wake || evt.ot_clear)
               state_next = sbcms_pkg::st_restart;
         end
         default: state_next = sbcms_pkg::st_init;
      endcase
   end

   // mode register; power-on enters init
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         state_reg <= sbcms_pkg::st_init;
      else
         state_reg <= state_next;
   end

   // reset delay counter, reloaded while reset output low and regulator below threshold
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         delay_cnt_reg <= 32'(RESET_DELAY_CYC);
      else if (state_next == sbcms_pkg::st_restart && state_reg != sbcms_pkg::st_restart)
         delay_cnt_reg <= 32'(RESET_DELAY_CYC);
      else if (!reset_output && !main_regulator_ok)
         delay_cnt_reg <= 32'(RESET_DELAY_CYC);
      else if (!delay_done)
         delay_cnt_reg <= delay_cnt_reg - 32'h1;
   end

   // reset output: low in restart, sleep and fail-safe, and until first delay ends
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reset_output   <= 1'b0;
         first_boot_reg <= 1'b1;
      end else begin
         if (first_boot_reg && delay_done && main_regulator_ok) begin
            reset_output   <= 1'b1;
            first_boot_reg <= 1'b0;
         end else if (state_next == sbcms_pkg::st_restart ||
                      state_next == sbcms_pkg::st_failsafe ||
                      state_next == sbcms_pkg::st_sleep) begin
            reset_output <= 1'b0;
         end else if (!first_boot_reg) begin
            reset_output <= 1'b1;
         end
      end
   end

   // pull-down on event pin while reset output low, delay running, regulator up, at first boot or with power_on_flag set
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         int_pulldown_en <= 1'b0;
      else
         int_pulldown_en <= main_regulator_ok && !reset_output && !delay_done &&
                            (first_boot_reg || power_on_flag);
   end

   // continuous filter on event pin level during the reset delay
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         filt_cnt_reg   <= 32'h0;
         int_filt_reg   <= 1'b0;
         int_stable_reg <= 1'b0;
      end else if (!int_pulldown_en) begin
         filt_cnt_reg   <= 32'h0;
         int_stable_reg <= 1'b0;
      end else if (int_sync_reg[2] != int_sync_reg[1]) begin
         filt_cnt_reg   <= 32'h0;
         int_stable_reg <= 1'b0;
      end else if (filt_cnt_reg >= 32'(FILT_CYC - 1)) begin
         int_filt_reg   <= int_sync_reg[2];
         int_stable_reg <= 1'b1;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 32'h1;
      end
   end

   // strap latch one cycle before reset output rises; relatched at each restart while power_on_flag is set
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         strap_level_latched <= 1'b0;
      else if (int_pulldown_en && !delay_done && delay_cnt_reg == 32'h1)
         strap_level_latched <= int_stable_reg & int_filt_reg;
   end

   // development mode strap caught while in init
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         development_mode <= 1'b0;
      else if (state_reg == sbcms_pkg::st_init && dbg_sync_reg[2] == dbg_sync_reg[1])
         development_mode <= !dbg_sync_reg[2];
   end

   // long open window watchdog, armed from reset and again at each restart entry until first trigger
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         win_open_reg <= 1'b1;
         win_cnt_reg  <= 32'(LONG_WIN_CYC);
      end else if (development_mode) begin
         win_cnt_reg <= win_cnt_reg;
      end else if (state_next == sbcms_pkg::st_restart && state_reg != sbcms_pkg::st_restart) begin
         win_open_reg <= 1'b1;
         win_cnt_reg  <= 32'(LONG_WIN_CYC);
      end else if (wd_trigger) begin
         win_open_reg <= 1'b0;
      end else if (win_open_reg && reset_output && win_cnt_reg != 32'h0) begin
         win_cnt_reg <= win_cnt_reg - 32'h1;
      end else if (win_cnt_reg == 32'h0) begin
         win_open_reg <= 1'b0;
      end
   end

   // failure counting and fail outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wd_fail_cnt_reg    <= 1'b0;
         fail_outputs       <= 1'b0;
         watchdog_fail_flag <= 1'b0;
      end else begin
         if (wd_fail_now) begin
            wd_fail_cnt_reg    <= 1'b1;
            watchdog_fail_flag <= 1'b1;
            if (threshold_select || wd_fail_cnt_reg)
               fail_outputs <= 1'b1;
         end
         if (ov_act && state_reg != sbcms_pkg::st_init)
            fail_outputs <= 1'b1;
      end
   end

   // overvoltage flag is sticky until power-on reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         main_overvoltage_flag <= 1'b0;
      else if (evt.ov_event)
         main_overvoltage_flag <= 1'b1;
   end

   // mode field mirrors software writes, cleared through restart
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         operating_mode_field <= `SBCMS_MODE_NORMAL;
      else if (state_next == sbcms_pkg::st_restart)
         operating_mode_field <= `SBCMS_MODE_NORMAL;
      else if (mode_write && state_next != state_reg && !wd_fail_now && !ov_act &&
               (state_reg == sbcms_pkg::st_normal || state_reg == sbcms_pkg::st_stop))
         operating_mode_field <= mode_write_data;
   end

   // registered status outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_state          <= sbcms_pkg::st_init;
         main_regulator_en   <= 1'b1;
         threshold_select_rb <= 1'b0;
      end else begin
         mode_state          <= state_next;
         main_regulator_en   <= state_next != sbcms_pkg::st_sleep &&
                                state_next != sbcms_pkg::st_failsafe;
         threshold_select_rb <= threshold_select;
      end
   end
endmodule : sbcms_top

// >>> test/sbcms_checker.sv
// port assertions for the operating-mode controller
// assumes binding to sbcms_top; one domain on ref_clk, rst async high
`timescale 1ns/1ps
`include "sbcms_defs.svh"
module sbcms_checker #(
   parameter int unsigned RESET_DELAY_CYC = 20
) (
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic                       spi_frame_done,
   input wire sbcms_pkg::sbcms_event_type evt,
   input wire logic                       overvoltage_reset_enable,
   input wire logic                       power_on_flag,
   input wire sbcms_pkg::sbcms_mode_type  mode_state,
   input wire logic                       reset_output,
   input wire logic                       main_regulator_en,
   input wire logic                       int_pulldown_en,
   input wire logic                       fail_outputs,
   input wire logic                       main_overvoltage_flag,
   input wire logic                       strap_level_latched,
   input wire logic                       development_mode,
   input wire logic [2:0]                 operating_mode_field
);
   localparam int RD_MAX = RESET_DELAY_CYC + 8;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // mode transitions and pin relations
   chk_init_spi_exit: assert property (
      mode_state == sbcms_pkg::st_init && spi_frame_done && evt == 5'h00
      |=> mode_state == sbcms_pkg::st_normal) else $error("init kept after frame");
   chk_init_wake_lost: assert property (
      mode_state == sbcms_pkg::st_init && evt == 5'h04 && !spi_frame_done
      |=> mode_state == sbcms_pkg::st_init) else $error("wake left init");
   chk_restart_holds_ro: assert property (
      (mode_state == sbcms_pkg::st_restart) [*2] |-> !reset_output)
      else $error("reset output high in restart");
   chk_restart_ends: assert property (
      $rose(mode_state == sbcms_pkg::st_restart)
      |-> ##[1:RD_MAX] mode_state == sbcms_pkg::st_normal) else $error("restart too long");
   chk_field_cleared: assert property (
      (mode_state == sbcms_pkg::st_restart) [*2]
      |-> operating_mode_field == `SBCMS_MODE_NORMAL) else $error("mode field kept");
   chk_failsafe_reg_off: assert property (
      mode_state == sbcms_pkg::st_failsafe |-> !main_regulator_en)
      else $error("regulator on in fail-safe");
   chk_failsafe_stays: assert property (
      mode_state == sbcms_pkg::st_failsafe && !evt.wake && !evt.ot_clear
      |=> mode_state == sbcms_pkg::st_failsafe) else $error("fail-safe left");
   chk_pulldown_window: assert property (
      int_pulldown_en |-> !reset_output) else $error("pull-down after reset release");
   chk_strap_latch_edge: assert property (
      $changed(strap_level_latched) |-> power_on_flag ##[0:2] $rose(reset_output))
      else $error("strap changed outside latch edge");
   chk_ov_off_flag_only: assert property (
      mode_state == sbcms_pkg::st_normal && evt == 5'h08 && !overvoltage_reset_enable
      |=> main_overvoltage_flag && $stable(fail_outputs) && mode_state == sbcms_pkg::st_normal)
      else $error("ov acted");
   chk_ov_on_reaction: assert property (
      mode_state == sbcms_pkg::st_normal && evt == 5'h08 && overvoltage_reset_enable
      |=> fail_outputs && main_overvoltage_flag && mode_state == (strap_level_latched ?
      sbcms_pkg::st_restart : sbcms_pkg::st_failsafe)) else $error("ov reaction wrong");
   // main scenarios reached
   cov_failsafe: cover property (mode_state == sbcms_pkg::st_failsafe);
   cov_sleep: cover property (mode_state == sbcms_pkg::st_sleep);
   cov_dev: cover property ($rose(reset_output) && development_mode);
endmodule : sbcms_checker
bind sbcms_top sbcms_checker #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_sbcms_checker (
   .ref_clk, .rst, .spi_frame_done, .evt, .overvoltage_reset_enable, .power_on_flag,
   .mode_state, .reset_output, .main_regulator_en, .int_pulldown_en, .fail_outputs,
   .main_overvoltage_flag, .strap_level_latched, .development_mode, .operating_mode_field);

// >>> test/sbcms_mcu_model.sv
// microcontroller model: ends SPI frames and triggers the watchdog
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
module sbcms_mcu_model (
   input  wire logic ref_clk,
   output logic      spi_frame_done,
   output logic      wd_trigger
);
   int slow_cycles = 0;
   // idle until asked
   initial begin
      spi_frame_done = 1'b0;
      wd_trigger     = 1'b0;
   end
   // one 16-bit frame, after an optional slow gap
   task automatic send_frame();
      repeat (slow_cycles) @(negedge ref_clk);
      @(negedge ref_clk) spi_frame_done = 1'b1;
      @(negedge ref_clk) spi_frame_done = 1'b0;
   endtask : send_frame
   // first trigger inside the long open window
   task automatic trigger_wd();
      @(negedge ref_clk) wd_trigger = 1'b1;
      @(negedge ref_clk) wd_trigger = 1'b0;
   endtask : trigger_wd
endmodule : sbcms_mcu_model

// >>> test/tb_top.sv
// self-checking bench for the operating-mode controller
// assumes shortened counts; inputs change on the falling edge
`timescale 1ns/1ps
`include "sbcms_defs.svh"
module tb_top;
   localparam int unsigned RD = 20;
   localparam int unsigned LW = 200;
   logic                       ref_clk, rst, spi_frame_done, wd_trigger, mode_write, wiggle;
   logic                       threshold_select, overvoltage_reset_enable, power_on_flag;
   logic                       main_regulator_ok, int_pin_in, debug_strap_pin;
   logic [2:0]                 mode_write_data, operating_mode_field;
   sbcms_pkg::sbcms_event_type evt;
   sbcms_pkg::sbcms_mode_type  mode_state;
   logic                       reset_output, main_regulator_en, int_pulldown_en, fail_outputs;
   logic                       main_overvoltage_flag, strap_level_latched, threshold_select_rb;
   logic                       development_mode, watchdog_fail_flag;
   int                         errors = 0, n_tests = 0, cyc = 0;
   sbcms_top #(.RESET_DELAY_CYC(RD), .LONG_WIN_CYC(LW), .FILT_CYC(4)) u_sbcms_top (.*);
   sbcms_mcu_model u_sbcms_mcu_model (.ref_clk, .spi_frame_done, .wd_trigger);
   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // unstable strap level and hang guard
   always @(negedge ref_clk) if (wiggle) int_pin_in <= ~int_pin_in;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic do_reset();
      power_on_flag = 1'b1; // a power-on reset sets the flag again
      rst = 1'b1;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
   endtask : do_reset
   task automatic wait_st(sbcms_pkg::sbcms_mode_type m, int lim);
      for (int i = 0; i < lim && mode_state !== m; i++) @(negedge ref_clk);
   endtask : wait_st
   task automatic wait_ro();
      for (int i = 0; i < 100 && reset_output !== 1'b1; i++) @(negedge ref_clk);
   endtask : wait_ro
   task automatic pulse(sbcms_pkg::sbcms_event_type e);
      @(negedge ref_clk) evt = e;
      @(negedge ref_clk) evt = 5'h00;
   endtask : pulse
   task automatic wr_mode(logic [2:0] c);
      @(negedge ref_clk) mode_write = 1'b1;
      mode_write_data = c;
      @(negedge ref_clk) mode_write = 1'b0;
   endtask : wr_mode
   task automatic s_startup();
      do_reset();
      repeat (3) @(negedge ref_clk);
      check("pulldown", int_pulldown_en, 1);
      check("ro_low", reset_output, 0);
      check("mode", mode_state, sbcms_pkg::st_init);
      wait_ro();
      check("ro_high", reset_output, 1);
      check("strap", strap_level_latched, 1);
      check("dev", development_mode, 0);
      check("sel_rb", threshold_select_rb, 0);
      u_sbcms_mcu_model.trigger_wd();
      pulse(5'h04);
      check("wake_init", mode_state, sbcms_pkg::st_init);
      u_sbcms_mcu_model.send_frame();
      check("init_exit", mode_state, sbcms_pkg::st_normal);
   endtask : s_startup
   task automatic s_modes();
      wr_mode(`SBCMS_MODE_STOP);
      check("stop", mode_state, sbcms_pkg::st_stop);
      wr_mode(`SBCMS_MODE_NORMAL);
      check("normal", mode_state, sbcms_pkg::st_normal);
      wr_mode(`SBCMS_MODE_SLEEP);
      check("sleep", mode_state, sbcms_pkg::st_sleep);
      check("sleep_reg", main_regulator_en, 0);
      check("field_sleep", operating_mode_field, `SBCMS_MODE_SLEEP);
      pulse(5'h04);
      wait_st(sbcms_pkg::st_normal, RD + 20);
      check("wake_exit", mode_state, sbcms_pkg::st_normal);
      check("field", operating_mode_field, `SBCMS_MODE_NORMAL);
      wr_mode(`SBCMS_MODE_RESET_REQ);
      check("reset_req", mode_state, sbcms_pkg::st_restart);
      wait_st(sbcms_pkg::st_normal, RD + 20);
      check("req_exit", mode_state, sbcms_pkg::st_normal);
   endtask : s_modes
   task automatic s_failures();
      overvoltage_reset_enable = 1'b0;
      pulse(5'h08);
      check("ov_flag", main_overvoltage_flag, 1);
      check("ov_fo", fail_outputs, 0);
      check("ov_mode", mode_state, sbcms_pkg::st_normal);
      for (int k = 0; k < 2; k++) begin
         pulse(5'h10);
         check("wd_mode", mode_state, sbcms_pkg::st_restart);
         check("wd_fo", fail_outputs, k[7:0]);
         check("ro_restart", reset_output, 0);
         @(negedge ref_clk);
         check("relatch_pd", int_pulldown_en, 1);
         wait_st(sbcms_pkg::st_normal, RD + 20);
         check("wd_exit", mode_state, sbcms_pkg::st_normal);
      end
      overvoltage_reset_enable = 1'b1;
      pulse(5'h08);
      check("ov_restart", mode_state, sbcms_pkg::st_restart);
   endtask : s_failures
   task automatic s_strap_zero();
      wiggle = 1'b1;
      threshold_select = 1'b1;
      do_reset();
      wait_ro();
      wiggle = 1'b0;
      @(negedge ref_clk) int_pin_in = 1'b1;
      power_on_flag = 1'b0;
      check("strap0", strap_level_latched, 0);
      check("sel_rb1", threshold_select_rb, 1);
      wait_st(sbcms_pkg::st_restart, LW + RD + 40);
      check("wd_restart", mode_state, sbcms_pkg::st_restart);
      check("wd_window", watchdog_fail_flag, 1);
      check("fo_first", fail_outputs, 1);
      @(negedge ref_clk);
      check("no_relatch_pd", int_pulldown_en, 0);
      wait_st(sbcms_pkg::st_normal, RD + 20);
      check("strap_kept", strap_level_latched, 0);
      pulse(5'h10);
      check("failsafe", mode_state, sbcms_pkg::st_failsafe);
      check("fs_reg", main_regulator_en, 0);
      pulse(5'h02);
      wait_st(sbcms_pkg::st_normal, RD + 20);
      check("fs_exit", mode_state, sbcms_pkg::st_normal);
      pulse(5'h08);
      check("ov_failsafe", mode_state, sbcms_pkg::st_failsafe);
   endtask : s_strap_zero
   task automatic s_dev();
      debug_strap_pin = 1'b0;
      do_reset();
      wait_ro();
      check("dev_on", development_mode, 1);
      repeat (LW + 20) @(negedge ref_clk);
      check("dev_init", mode_state, sbcms_pkg::st_init);
   endtask : s_dev
   task automatic conclude();
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      mode_write = 1'b0;
      mode_write_data = 3'h0;
      evt = 5'h00;
      threshold_select = 1'b0;
      overvoltage_reset_enable = 1'b0;
      main_regulator_ok = 1'b1;
      int_pin_in = 1'b1;
      debug_strap_pin = 1'b1;
      wiggle = 1'b0;
      s_startup();
      s_modes();
      s_failures();
      s_strap_zero();
      s_dev();
      conclude();
   end
endmodule : tb_top
